// file: inc/cspc_defines.svh
`ifndef CSPC_DEFINES_SVH
`define CSPC_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CSPC_ADDR_MSB 11
`define CSPC_SKT_CTRL_OFF 12'h010
`define CSPC_SKT_CTRL_RESET 32'h0000_0400

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSPC_VPP_LSB 0
`define CSPC_VPP_MSB 2
`define CSPC_VCC_LSB 4
`define CSPC_VCC_MSB 6
`define CSPC_POLICY_BIT 7
`define CSPC_VEN_BIT 9
`define CSPC_STD_BIT 10
`define CSPC_ACT_BIT 11
`define CSPC_RSVD_HI_LSB 12
`define CSPC_RSVD_MID_BIT 8
`define CSPC_RSVD_LO_BIT 3

// ----------------------------------------------------------------
// reset values and responses
// ----------------------------------------------------------------
`define CSPC_SUPPLY_OFF 3'h0
`define CSPC_RESP_OKAY 2'h0
`define CSPC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CSPC_IDLE_CLOCKS 4'h8

`endif

// file: inc/cspc_pkg.sv
package cspc_pkg;

   // ----------------------------------------------------------------
   // bus carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] addr;
      logic [2:0] prot;
   } cspc_addr_t;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0] strb;
   } cspc_wdata_t;

   typedef struct packed {
      logic [1:0] resp;
   } cspc_bresp_t;

   typedef struct packed {
      logic [31:0] data;
      logic [1:0] resp;
   } cspc_rdata_t;

   // ----------------------------------------------------------------
   // supply request codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CSPC_SUP_OFF = 3'b000,
      CSPC_SUP_12V = 3'b001,
      CSPC_SUP_5V = 3'b010,
      CSPC_SUP_3V3 = 3'b011,
      CSPC_SUP_XV = 3'b100,
      CSPC_SUP_YV = 3'b101
   } cspc_supply_t;

endpackage

// file: logic/cspc_supply_guard.sv
`timescale 1ns/1ns
`include "cspc_defines.svh"

module cspc_supply_guard (
   input wire logic clk_in, // core clock
   input wire logic rst_in, // sync reset, high
   input wire logic [2:0] vcc_req_in, // main supply request
   input wire logic [2:0] vpp_req_in, // programming supply request
   input wire logic card_present_in, // card seated
   input wire logic [3:0] card_ok_in, // card accepts 5v, 3v3, xv, yv
   input wire logic retest_in, // re-interrogation pulse
   input wire logic force_type_in, // forced card type pulse
   output logic [2:0] vcc_out, // applied main supply
   output logic [2:0] vpp_out, // applied programming supply
   output logic ctrl_en_out // socket power control enabled
);

   logic ctrl_en_reg;
   logic [2:0] vcc_reg;
   logic [2:0] vpp_reg;
   logic [2:0] vcc_idx;
   logic [2:0] vpp_idx;

   // ----------------------------------------------------------------
   // qualification
   // ----------------------------------------------------------------
   // reserved codes fall through to off
   wire vcc_legal = (vcc_req_in >= 3'h2) && (vcc_req_in <= 3'h5);
   wire vpp_legal = (vpp_req_in >= 3'h1) && (vpp_req_in <= 3'h5);
   assign vcc_idx = vcc_req_in - 3'h2;
   assign vpp_idx = vpp_req_in - 3'h2;
   wire vcc_ok = ctrl_en_reg && card_present_in && vcc_legal && card_ok_in[vcc_idx[1:0]];
   // programming supply only rides on an applied main supply
   wire vpp_ok = vcc_ok && vpp_legal
      && ((vpp_req_in == 3'h1) || card_ok_in[vpp_idx[1:0]]);

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         ctrl_en_reg <= 1'b1;
         vcc_reg <= `CSPC_SUPPLY_OFF;
         vpp_reg <= `CSPC_SUPPLY_OFF;
      end
      else
      begin
         ctrl_en_reg <= retest_in ? 1'b1 : (force_type_in ? 1'b0 : ctrl_en_reg);
         vcc_reg <= vcc_ok ? vcc_req_in : `CSPC_SUPPLY_OFF;
         vpp_reg <= vpp_ok ? vpp_req_in : `CSPC_SUPPLY_OFF;
      end
   end

   assign vcc_out = vcc_reg;
   assign vpp_out = vpp_reg;
   assign ctrl_en_out = ctrl_en_reg;

   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_no_rsvd_supply: assert property ((vcc_out != 3'h1) && (vcc_out <= 3'h5))
      else $error("reserved main supply code applied");
   a_retest_enable: assert property (retest_in |=> ctrl_en_out)
      else $error("retest did not re-enable power control");
   a_supply_gated: assert property (!card_present_in |=> vcc_out == 3'h0 && vpp_out == 3'h0)
      else $error("supply applied without a card");

endmodule

// file: logic/cspc_clk_stop.sv
`timescale 1ns/1ns
`include "cspc_defines.svh"

module cspc_clk_stop (
   input wire logic clk_in, // core clock
   input wire logic rst_in, // sync reset, high
   input wire logic idle_in, // card interface idle this clock
   input wire logic host_req_in, // host bus master request
   input wire logic policy_in, // clock stop policy
   output logic stop_req_out // ask clock run master to stop
);

   logic [3:0] idle_cnt_reg;
   logic [3:0] idle_cnt_next;
   logic stop_reg;

   // ----------------------------------------------------------------
   // idle counter
   // ----------------------------------------------------------------
   wire idle_full = (idle_cnt_reg == `CSPC_IDLE_CLOCKS);
   assign idle_cnt_next = !idle_in ? 4'h0 : (idle_full ? idle_cnt_reg : idle_cnt_reg + 4'h1);
   wire stop_next = idle_full && idle_in && (policy_in || host_req_in);

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         idle_cnt_reg <= 4'h0;
         stop_reg <= 1'b0;
      end
      else
      begin
         idle_cnt_reg <= idle_cnt_next;
         stop_reg <= stop_next;
      end
   end

   assign stop_req_out = stop_reg;

   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_idle_run;
      idle_in [*8] ##1 idle_in;
   endsequence

   a_stop_needs_host: assert property (s_idle_run ##0 (!policy_in && !host_req_in) |=> !stop_req_out)
      else $error("clock stop without host request");
   a_stop_any_idle: assert property (s_idle_run ##0 policy_in |=> stop_req_out)
      else $error("clock not stopped after idle run");
   a_stop_idle_only: assert property (!idle_in |=> !stop_req_out)
      else $error("clock stop while busy");

endmodule

// file: logic/cspc_socket_ctrl.sv
`timescale 1ns/1ns
`include "cspc_defines.svh"

module cspc_socket_ctrl (
   input wire logic clk_in, // core clock, 250 MHz
   input wire logic rst_in, // sync reset, high
   input wire logic s_awvalid_in, // write address valid
   input wire cspc_pkg::cspc_addr_t s_aw_in, // write address
   output logic s_awready_out, // write address ready
   input wire logic s_wvalid_in, // write data valid
   input wire cspc_pkg::cspc_wdata_t s_w_in, // write data and strobes
   output logic s_wready_out, // write data ready
   output logic s_bvalid_out, // write response valid
   output cspc_pkg::cspc_bresp_t s_b_out, // write response
   input wire logic s_bready_in, // write response ready
   input wire logic s_arvalid_in, // read address valid
   input wire cspc_pkg::cspc_addr_t s_ar_in, // read address
   output logic s_arready_out, // read address ready
   output logic s_rvalid_out, // read data valid
   output cspc_pkg::cspc_rdata_t s_r_out, // read data and response
   input wire logic s_rready_in, // read data ready
   input wire logic card_present_in, // card seated in socket
   input wire logic [3:0] card_ok_in, // card accepts 5v, 3v3, xv, yv
   input wire logic card_if_idle_in, // card interface idle this clock
   input wire logic host_master_req_in, // host bus master request
   input wire logic card_voltage_retest_in, // retest command pulse
   input wire logic forced_card_type_in, // forced card type pulse
   output logic [2:0] main_supply_out, // applied main supply code
   output logic [2:0] program_supply_out, // applied programming supply code
   output logic power_ctrl_enabled_out, // socket power control enabled
   output logic video_path_enable_out, // video path enabled
   output logic video_path_active_out, // video path active
   output logic clock_stop_req_out, // stop card clock request
   output logic reinterrogate_out // re-interrogate card pulse
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [2:0] main_supply_request_reg;
   logic [2:0] program_supply_request_reg;
   logic clock_stop_policy_reg;
   logic video_path_enable_reg;
   logic video_path_active_reg;
   logic reinterrogate_reg;

   // ----------------------------------------------------------------
   // bus state
   // ----------------------------------------------------------------
   logic awready_reg;
   logic wready_reg;
   logic aw_got_reg;
   logic w_got_reg;
   logic bvalid_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic rd_hit_reg;
   cspc_pkg::cspc_addr_t aw_reg;
   cspc_pkg::cspc_wdata_t w_reg;
   cspc_pkg::cspc_bresp_t b_reg;
   cspc_pkg::cspc_rdata_t r_reg;

   logic [31:0] ctrl_rd;

   // window bits of the register's byte offset; a literal cannot be sliced
   localparam logic [`CSPC_ADDR_MSB:0] ctrl_off = `CSPC_SKT_CTRL_OFF;

   // ----------------------------------------------------------------
   // handshakes and decode
   // ----------------------------------------------------------------
   wire aw_hs = s_awvalid_in && awready_reg;
   wire w_hs = s_wvalid_in && wready_reg;
   wire b_hs = bvalid_reg && s_bready_in;
   wire ar_hs = s_arvalid_in && arready_reg;
   wire r_hs = rvalid_reg && s_rready_in;
   // write fires once address and data are both held
   wire wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
   // only the low window bits decode; the word offset ignores byte bits
   wire wr_hit = (aw_reg.addr[`CSPC_ADDR_MSB:2] == ctrl_off[`CSPC_ADDR_MSB:2]);
   wire rd_hit = (s_ar_in.addr[`CSPC_ADDR_MSB:2] == ctrl_off[`CSPC_ADDR_MSB:2]);
   wire wr_lane0 = wr_fire && wr_hit && w_reg.strb[0];
   wire wr_lane1 = wr_fire && wr_hit && w_reg.strb[1];

   // ----------------------------------------------------------------
   // read image
   // ----------------------------------------------------------------
   // reserved positions are tied low
   assign ctrl_rd = {
      20'h00000,
      video_path_enable_reg,
      1'b1,
      video_path_enable_reg,
      1'b0,
      clock_stop_policy_reg,
      main_supply_request_reg,
      1'b0,
      program_supply_request_reg
   };

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   wire awready_next = aw_hs ? 1'b0 : ((!aw_got_reg && !bvalid_reg) ? 1'b1 : awready_reg);
   wire wready_next = w_hs ? 1'b0 : ((!w_got_reg && !bvalid_reg) ? 1'b1 : wready_reg);
   wire aw_got_next = aw_hs ? 1'b1 : (wr_fire ? 1'b0 : aw_got_reg);
   wire w_got_next = w_hs ? 1'b1 : (wr_fire ? 1'b0 : w_got_reg);
   wire bvalid_next = wr_fire ? 1'b1 : (b_hs ? 1'b0 : bvalid_reg);
   wire arready_next = ar_hs ? 1'b0 : ((!rvalid_reg) ? 1'b1 : arready_reg);
   wire rvalid_next = ar_hs ? 1'b1 : (r_hs ? 1'b0 : rvalid_reg);

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         aw_reg <= '0;
         w_reg <= '0;
         b_reg <= '0;
      end
      else
      begin
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         bvalid_reg <= bvalid_next;
         if (aw_hs)
            aw_reg <= s_aw_in;
         if (w_hs)
            w_reg <= s_w_in;
         if (wr_fire)
            b_reg.resp <= wr_hit ? `CSPC_RESP_OKAY : `CSPC_RESP_SLVERR;
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rd_hit_reg <= 1'b0;
         r_reg <= '0;
      end
      else
      begin
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         if (ar_hs)
         begin
            rd_hit_reg <= rd_hit;
            r_reg.data <= rd_hit ? ctrl_rd : 32'h00000000;
            r_reg.resp <= rd_hit ? `CSPC_RESP_OKAY : `CSPC_RESP_SLVERR;
         end
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         program_supply_request_reg <= `CSPC_SUPPLY_OFF;
         main_supply_request_reg <= `CSPC_SUPPLY_OFF;
         clock_stop_policy_reg <= 1'b0;
         video_path_enable_reg <= 1'b0;
         video_path_active_reg <= 1'b0;
         reinterrogate_reg <= 1'b0;
      end
      else
      begin
         // lane 0 holds both supply fields and the policy; bit 3 is dropped
         if (wr_lane0)
         begin
            program_supply_request_reg <= w_reg.data[`CSPC_VPP_MSB:`CSPC_VPP_LSB];
            main_supply_request_reg <= w_reg.data[`CSPC_VCC_MSB:`CSPC_VCC_LSB];
            clock_stop_policy_reg <= w_reg.data[`CSPC_POLICY_BIT];
         end
         // lane 1 only carries the enable; bits 8, 10, 11 are not stored
         if (wr_lane1)
            video_path_enable_reg <= w_reg.data[`CSPC_VEN_BIT];
         video_path_active_reg <= wr_lane1 ? w_reg.data[`CSPC_VEN_BIT]
            : video_path_enable_reg;
         reinterrogate_reg <= card_voltage_retest_in;
      end
   end

   // ----------------------------------------------------------------
   // socket side
   // ----------------------------------------------------------------
   cspc_supply_guard u_guard (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .vcc_req_in(main_supply_request_reg),
      .vpp_req_in(program_supply_request_reg),
      .card_present_in(card_present_in),
      .card_ok_in(card_ok_in),
      .retest_in(card_voltage_retest_in),
      .force_type_in(forced_card_type_in),
      .vcc_out(main_supply_out),
      .vpp_out(program_supply_out),
      .ctrl_en_out(power_ctrl_enabled_out)
   );

   cspc_clk_stop u_clk_stop (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .idle_in(card_if_idle_in),
      .host_req_in(host_master_req_in),
      .policy_in(clock_stop_policy_reg),
      .stop_req_out(clock_stop_req_out)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign s_awready_out = awready_reg;
   assign s_wready_out = wready_reg;
   assign s_bvalid_out = bvalid_reg;
   assign s_b_out = b_reg;
   assign s_arready_out = arready_reg;
   assign s_rvalid_out = rvalid_reg;
   assign s_r_out = r_reg;
   assign video_path_enable_out = video_path_enable_reg;
   assign video_path_active_out = video_path_active_reg;
   assign reinterrogate_out = reinterrogate_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_ctrl_write_lane1;
      wr_lane1;
   endsequence

   sequence s_ctrl_read_done;
      rvalid_reg && rd_hit_reg;
   endsequence

   a_rsvd_read_zero: assert property (s_ctrl_read_done |->
      r_reg.data[31:12] == 20'h00000 && !r_reg.data[8] && !r_reg.data[3])
      else $error("reserved bits read nonzero");

   a_activity_match: assert property (s_ctrl_read_done |->
      r_reg.data[`CSPC_ACT_BIT] == r_reg.data[`CSPC_VEN_BIT])
      else $error("video activity differs from enable");

   a_activity_pin: assert property (##1 video_path_active_out == video_path_enable_out)
      else $error("video activity output lags enable");

   a_std_model_one: assert property (s_ctrl_read_done |-> r_reg.data[`CSPC_STD_BIT])
      else $error("standard video model bit not set");

   a_reset_image: assert property ($fell(rst_in) |-> ctrl_rd == `CSPC_SKT_CTRL_RESET)
      else $error("register reset image wrong");

   a_video_write: assert property (s_ctrl_write_lane1 |=>
      video_path_enable_out == $past(w_reg.data[`CSPC_VEN_BIT]))
      else $error("video enable write not taken");

   a_unmapped_write: assert property (wr_fire && !wr_hit |=> $stable(ctrl_rd)
      && s_b_out.resp == `CSPC_RESP_SLVERR)
      else $error("unmapped write changed register");

   a_write_response: assert property (wr_fire |=> s_bvalid_out [*1] ##0 !s_awready_out)
      else $error("write response missing");

   a_read_latency: assert property (ar_hs |=> s_rvalid_out ##0 !s_arready_out)
      else $error("read answer not one cycle after address");

   a_field_store: assert property (wr_lane0 |=>
      main_supply_request_reg == $past(w_reg.data[6:4])
      && program_supply_request_reg == $past(w_reg.data[2:0]))
      else $error("supply request fields not stored");

   a_retest_pulse: assert property (card_voltage_retest_in |=> reinterrogate_out)
      else $error("retest not forwarded");

   a_supply_card_ok: assert property (main_supply_out != 3'h0 |->
      $past(card_present_in) && $past(power_ctrl_enabled_out))
      else $error("supply applied without qualification");

   // ----------------------------------------------------------------
   // socket-side checks
   // ----------------------------------------------------------------
   // qualification restated here so a slip in the guard is caught
   wire main_req_legal = (main_supply_request_reg >= 3'h2) && (main_supply_request_reg <= 3'h5);
   wire [2:0] main_ok_idx = main_supply_request_reg - 3'h2;
   wire main_qualified = power_ctrl_enabled_out && card_present_in && main_req_legal
      && card_ok_in[main_ok_idx[1:0]];

   sequence s_retest_and_force;
      card_voltage_retest_in && forced_card_type_in;
   endsequence

   a_supply_applied: assert property (main_qualified |=>
      main_supply_out == $past(main_supply_request_reg))
      else $error("qualified main supply not applied");

   a_supply_refused: assert property (!main_qualified |=> main_supply_out == 3'h0)
      else $error("unqualified main supply applied");

   a_prog_rsvd_off: assert property (program_supply_request_reg >= 3'h6 |=>
      program_supply_out == 3'h0)
      else $error("reserved programming code applied");

   a_retest_wins: assert property (s_retest_and_force |=> power_ctrl_enabled_out)
      else $error("forced type beat retest");

   a_force_disables: assert property (forced_card_type_in && !card_voltage_retest_in |=>
      !power_ctrl_enabled_out)
      else $error("forced type left power control on");

   a_policy_store: assert property (wr_lane0 |=>
      clock_stop_policy_reg == $past(w_reg.data[`CSPC_POLICY_BIT]))
      else $error("clock stop policy not stored");

   a_video_hold: assert property (!wr_lane1 |=> $stable(video_path_enable_out))
      else $error("video enable changed without a write");

   a_lane0_masked: assert property (wr_fire && !w_reg.strb[0] |=>
      $stable(main_supply_request_reg) && $stable(program_supply_request_reg))
      else $error("supply fields written without lane 0");

endmodule

// file: bench/cspc_card_model.sv
`timescale 1ns/1ns

module cspc_card_model (
   input wire logic clk_in, // core clock
   input wire logic rst_in, // sync reset, high
   input wire logic seated_in, // card inserted
   input wire logic [3:0] card_type_in, // voltages the card tolerates
   input wire logic busy_in, // card traffic under way
   input wire logic host_in, // host master wants the bus
   input wire logic reinterrogate_in, // device re-reads voltage sense
   output logic card_present_out, // card seated
   output logic [3:0] card_ok_out, // sensed acceptable voltages
   output logic card_if_idle_out, // interface idle
   output logic host_req_out // host bus master request
);
   // ----------------------------------------------------------------
   // card sense
   // ----------------------------------------------------------------
   // sense only refreshes on insertion or re-interrogation, so a stale
   // card type stays visible until the device asks again
   always_ff @(posedge clk_in)
   begin
      card_present_out <= seated_in && !rst_in;
      if (rst_in || !seated_in)
         card_ok_out <= 4'h0;
      else if (!card_present_out || reinterrogate_in)
         card_ok_out <= card_type_in;
   end
   assign card_if_idle_out = !busy_in;
   assign host_req_out = host_in;
endmodule

// file: bench/card_socket_control_register_tb.sv
`timescale 1ns/1ns

module card_socket_control_register_tb;
   logic clk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   cspc_pkg::cspc_addr_t s_aw, s_ar;
   cspc_pkg::cspc_wdata_t s_w;
   cspc_pkg::cspc_bresp_t s_b;
   cspc_pkg::cspc_rdata_t s_r;
   cspc_pkg::cspc_rdata_t exp_q[$];
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic present, idle, hreq, retest, forced, seated, busy, host, reint, pen, ven, vact, stop;
   logic [3:0] card_ok, card_type;
   logic [2:0] vcc, vpp, v, ev;
   logic [1:0] r;
   int errors, compares;
   integer seed;

   cspc_card_model card (.clk_in(clk), .rst_in(rst), .seated_in(seated),
      .card_type_in(card_type), .busy_in(busy), .host_in(host), .reinterrogate_in(reint),
      .card_present_out(present), .card_ok_out(card_ok), .card_if_idle_out(idle),
      .host_req_out(hreq));

   cspc_socket_ctrl DUT (.clk_in(clk), .rst_in(rst), .s_awvalid_in(s_awvalid),
      .s_aw_in(s_aw), .s_awready_out(s_awready), .s_wvalid_in(s_wvalid), .s_w_in(s_w),
      .s_wready_out(s_wready), .s_bvalid_out(s_bvalid), .s_b_out(s_b),
      .s_bready_in(s_bready), .s_arvalid_in(s_arvalid), .s_ar_in(s_ar),
      .s_arready_out(s_arready), .s_rvalid_out(s_rvalid), .s_r_out(s_r),
      .s_rready_in(s_rready), .card_present_in(present), .card_ok_in(card_ok),
      .card_if_idle_in(idle), .host_master_req_in(hreq), .card_voltage_retest_in(retest),
      .forced_card_type_in(forced), .main_supply_out(vcc), .program_supply_out(vpp),
      .power_ctrl_enabled_out(pen), .video_path_enable_out(ven),
      .video_path_active_out(vact), .clock_stop_req_out(stop), .reinterrogate_out(reint));

   // ----------------------------------------------------------------
   // checking helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      compares++;
      if (seen !== want)
      begin
         errors++;
         $display("ERROR %0t: got %h want %h", $time, seen, want);
      end
   endtask

   task automatic stop_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic tick(inout int n);
      n++;
      if (n > 50)
      begin
         errors++;
         stop_test();
      end
   endtask

   // ----------------------------------------------------------------
   // bus master
   // ----------------------------------------------------------------
   // handshakes are judged at the falling edge, where all levels are settled
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] st);
      logic aw_d, w_d, b_d;
      int n;
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b0;
      n = 0;
      s_awvalid <= 1'b1;
      s_aw <= {a, 3'h0};
      s_wvalid <= 1'b1;
      s_w <= {d, st};
      while (!(aw_d && w_d))
      begin
         @(negedge clk);
         aw_d = aw_d | (s_awvalid && s_awready);
         w_d = w_d | (s_wvalid && s_wready);
         @(posedge clk);
         if (aw_d)
            s_awvalid <= 1'b0;
         if (w_d)
            s_wvalid <= 1'b0;
         tick(n);
      end
      s_bready <= 1'b1;
      while (!b_d)
      begin
         @(negedge clk);
         b_d = s_bvalid;
         r = s_b.resp;
         @(posedge clk);
         tick(n);
      end
      s_bready <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic rd(input logic [31:0] a, input cspc_pkg::cspc_rdata_t want);
      logic ar_d, r_d;
      int n;
      ar_d = 1'b0;
      r_d = 1'b0;
      n = 0;
      exp_q.push_back(want);
      s_arvalid <= 1'b1;
      s_ar <= {a, 3'h0};
      while (!ar_d)
      begin
         @(negedge clk);
         ar_d = s_arready;
         @(posedge clk);
         tick(n);
      end
      s_arvalid <= 1'b0;
      s_rready <= 1'b1;
      while (!r_d)
      begin
         @(negedge clk);
         r_d = s_rvalid;
         @(posedge clk);
         tick(n);
      end
      s_rready <= 1'b0;
   endtask

   always @(negedge clk)
   begin
      if (s_rvalid && s_rready && exp_q.size() > 0)
         check(s_r, exp_q.pop_front());
   end

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial
   begin
      seed = 32'hc403;
      {errors, compares} = 0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, retest, forced, host} = 8'h0;
      {s_aw, s_ar, s_w} = 0;
      {rst, seated, busy, card_type} = 7'h7f;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(32'h10, {32'h400, 2'h0});
      for (int c = 0; c < 8; c++)
      begin
         v = 3'(c);
         ev = (v >= 3'h2 && v <= 3'h5) ? v : 3'h0;
         wr(32'h10, ($random(seed) & 32'hfffff108) | {25'h0, v, 1'b0, v}, 4'hf);
         check({32'h0, r}, 34'h0);
         check({31'h0, vcc}, {31'h0, ev});
         check({31'h0, vpp}, {31'h0, ev});
         rd(32'h10, {32'h400 | {25'h0, v, 1'b0, v}, 2'h0});
      end
      wr(32'h10, 32'hffffffff, 4'h2);
      check({32'h0, ven, vact}, 34'h3);
      rd(32'h10, {32'he77, 2'h0});
      wr(32'h10, 32'h0, 4'h2);
      check({32'h0, ven, vact}, 34'h0);
      wr(32'h14, $random(seed), 4'hf);
      check({32'h0, r}, 34'h2);
      rd(32'h14, {32'h0, 2'h2});
      rd(32'h10, {32'h477, 2'h0});
      card_type <= 4'he;
      retest <= 1'b1;
      @(posedge clk);
      retest <= 1'b0;
      repeat (3) @(posedge clk);
      wr(32'h10, 32'h20, 4'hf);
      check({31'h0, vcc}, 34'h0);
      wr(32'h10, 32'h33, 4'hf);
      check({28'h0, vcc, vpp}, 34'h1b);
      forced <= 1'b1;
      @(posedge clk);
      forced <= 1'b0;
      repeat (2) @(posedge clk);
      check({32'h0, pen, vcc[0]}, 34'h0);
      retest <= 1'b1;
      @(posedge clk);
      retest <= 1'b0;
      @(negedge clk);
      check({32'h0, reint, pen}, 34'h3);
      repeat (2) @(posedge clk);
      check({31'h0, vcc}, 34'h3);
      {forced, retest} <= 2'h3;
      @(posedge clk);
      {forced, retest} <= 2'h0;
      @(negedge clk);
      check({33'h0, pen}, 34'h1);
      @(posedge clk);
      busy <= 1'b0;
      repeat (14) @(posedge clk);
      check({33'h0, stop}, 34'h0);
      host <= 1'b1;
      repeat (3) @(posedge clk);
      check({33'h0, stop}, 34'h1);
      host <= 1'b0;
      busy <= 1'b1;
      wr(32'h10, 32'hb0, 4'hf);
      check({33'h0, stop}, 34'h0);
      busy <= 1'b0;
      repeat (6) @(posedge clk);
      check({33'h0, stop}, 34'h0);
      repeat (6) @(posedge clk);
      check({33'h0, stop}, 34'h1);
      repeat (4) @(posedge clk);
      check(34'(exp_q.size()), 34'h0);
      stop_test();
   end
endmodule
